// file: hdl/agc_pkg.sv
// Shared constants and types for the serial gauge link and its two ends
package agc_pkg;
  // Frame layout: three 10-bit gauge fields, first bit shifted out is MSB
  localparam int GAUGE_W       = 10;
  localparam int MINOR_RES_W   = 9;
  localparam int FRAME_W       = 30;
  localparam int FLD_MAJOR_LSB = 20;
  localparam int FLD_A_LSB     = 10;
  localparam int FLD_B_LSB     = 0;
  localparam int DAC_W         = 7;
  localparam int SECT_W        = 3;
  // Status bits overwrite the top of the frame on chip select rise
  localparam int STAT_W        = 4;
  localparam int ST_MINOR_OC   = 29;
  localparam int ST_MAJOR_OC   = 28;
  localparam int ST_THERMAL    = 27;
  localparam int ST_RUN        = 26;
  localparam int ST_LSB        = 26;
  // Timing of the shift clock made by the controller
  localparam int CLK_NS        = 4;
  localparam int T_CYC_NS      = 625;
  localparam int SCLK_HALF_CYC = (T_CYC_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int CNT_W         = 8;
  // Controller register map, byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MAJOR  = 8'h04;
  localparam logic [7:0] ADDR_MINA   = 8'h08;
  localparam logic [7:0] ADDR_MINB   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_GOE      = 0;
  localparam int CTRL_PARK     = 1;
  localparam int CTRL_START    = 2;
  localparam int STS_BUSY      = 0;
  localparam int STS_FAULT     = 1;
  localparam int STS_RET_LSB   = 2;
  localparam int STS_PARK      = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  typedef enum logic [1:0] {
    AGC_STANDBY,
    AGC_STARTUP,
    AGC_NORMAL
  } agc_mode_t;
  typedef enum logic [2:0] {
    AGC_L_IDLE,
    AGC_L_LOW,
    AGC_L_HIGH,
    AGC_L_TAIL,
    AGC_L_GAP
  } agc_link_st_t;
endpackage

// file: hdl/agc_link_if.sv
// Serial link between gauge controller and gauge driver
`timescale 1ns/1ps
interface agc_link_if;
  logic cs;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic gauge_output_enable;
  logic fault_drv;
  logic fault_oe;
  logic fault_flag_n;
  // Open-drain with pull-up: released line reads high
  assign fault_flag_n = fault_oe ? fault_drv : 1'b1;
  modport dev (
    input  cs,
    input  sclk,
    input  serial_in,
    input  gauge_output_enable,
    input  fault_flag_n,
    output serial_out,
    output fault_drv,
    output fault_oe
  );
  modport ctl (
    output cs,
    output sclk,
    output serial_in,
    output gauge_output_enable,
    input  serial_out,
    input  fault_flag_n
  );
endinterface

// file: hdl/agc_dev.sv
// Gauge driver end: shift register, latches, status and output gating
`timescale 1ns/1ps
// Function
// - Shift serial_in on shift clock rise while selected
// - serial_out feeds next driver in chain
// - Fault flag is open-drain, active low
// - Chip select rise loads status into first bits
// - Fault flag low while any fault is set
// - Status: minor overcurrent, major overcurrent, thermal, run
// - Chip select fall latches gauge fields
// - Major gauge low seven bits feed converter
// - Major top three bits choose coil and polarity
// - Ten bit fields; minor gauges use nine
// - Overvoltage disables buffers and supply switch
// - Overtemperature disables buffers, recovers automatically
// - Serial and status keep working in shutdown
// - Run and enable low gives standby
// - Run only: supply on, minors zero, major off
// - Data accepted while gauge enable low
// - Gauge enable high enables major; normal mode
// - Run falling with enable high stays normal
// - Controller parks needles before dropping enable
module agc_dev (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  agc_link_if.dev                           link,
  input  wire logic                         run,
  input  wire logic                         minor_overcurrent,
  input  wire logic                         major_overcurrent,
  input  wire logic                         over_temp,
  input  wire logic                         over_volt,
  output logic                              supply_switch_drive,
  output logic                              major_gauge_oe,
  output logic [agc_pkg::DAC_W-1:0]         major_gauge_dac,
  output logic                              major_dac_to_cos,
  output logic                              major_sin_neg,
  output logic                              major_cos_neg,
  output logic                              minor_gauge_oe,
  output logic [agc_pkg::MINOR_RES_W-1:0]   minor_gauge_a,
  output logic [agc_pkg::MINOR_RES_W-1:0]   minor_gauge_b
);

  localparam int I_CS    = 0;
  localparam int I_SCLK  = 1;
  localparam int I_SDI   = 2;
  localparam int I_GOE   = 3;
  localparam int I_RUN   = 4;
  localparam int I_MINOC = 5;
  localparam int I_MAJOC = 6;
  localparam int I_TEMP  = 7;
  localparam int I_VOLT  = 8;
  localparam int N_PINS  = 9;
  localparam int FW      = agc_pkg::FRAME_W;
  localparam int GW      = agc_pkg::GAUGE_W;

  logic [N_PINS-1:0]               pin_raw;
  logic [N_PINS-1:0]               meta_q;
  logic [N_PINS-1:0]               sync_q;
  logic [N_PINS-1:0]               prev_q;
  logic                            cs_rise;
  logic                            cs_fall;
  logic                            sclk_rise;
  logic [FW-1:0]                   sr_q;
  logic [agc_pkg::STAT_W-1:0]      status_now;
  logic [GW-1:0]                   major_q;
  logic [GW-1:0]                   minor_a_q;
  logic [GW-1:0]                   minor_b_q;
  agc_pkg::agc_mode_t              mode_d;
  agc_pkg::agc_mode_t              mode_q;
  logic                            any_fault;
  logic                            buf_kill;
  logic [agc_pkg::SECT_W-1:0]      section;
  logic                            fault_oe_q;
  logic                            fault_drv_q;

  assign pin_raw = {over_volt, over_temp, major_overcurrent,
                    minor_overcurrent, run, link.gauge_output_enable,
                    link.serial_in, link.sclk, link.cs};

  // Every pin passes two flops; edges are found after the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign cs_rise   = sync_q[I_CS] & ~prev_q[I_CS];
  assign cs_fall   = ~sync_q[I_CS] & prev_q[I_CS];
  assign sclk_rise = sync_q[I_SCLK] & ~prev_q[I_SCLK];

  // Status is live; it is not gated by the shutdown paths
  assign status_now = {sync_q[I_MINOC], sync_q[I_MAJOC],
                       sync_q[I_TEMP], sync_q[I_RUN]};

  // Shift register; top four bits take status on select rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_q <= '0;
    end else if (cs_rise) begin
      sr_q[agc_pkg::ST_MINOR_OC] <= status_now[3];
      sr_q[agc_pkg::ST_MAJOR_OC] <= status_now[2];
      sr_q[agc_pkg::ST_THERMAL]  <= status_now[1];
      sr_q[agc_pkg::ST_RUN]      <= status_now[0];
    end else if (sync_q[I_CS] && sclk_rise) begin
      sr_q <= {sr_q[FW-2:0], sync_q[I_SDI]};
    end
  end

  // Oldest bit leaves first so chained drivers see a plain delay line
  assign link.serial_out = sr_q[FW-1];

  // Latch update ignores mode, so data can be preloaded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      major_q   <= '0;
      minor_a_q <= '0;
      minor_b_q <= '0;
    end else if (cs_fall) begin
      major_q   <= sr_q[agc_pkg::FLD_MAJOR_LSB +: GW];
      minor_a_q <= sr_q[agc_pkg::FLD_A_LSB +: GW];
      minor_b_q <= sr_q[agc_pkg::FLD_B_LSB +: GW];
    end
  end

  // Enable high keeps normal mode regardless of run
  always_comb begin
    if (sync_q[I_GOE]) begin
      mode_d = agc_pkg::AGC_NORMAL;
    end else if (sync_q[I_RUN]) begin
      mode_d = agc_pkg::AGC_STARTUP;
    end else begin
      mode_d = agc_pkg::AGC_STANDBY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= agc_pkg::AGC_STANDBY;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Shutdown gates only the outputs; serial and status paths run on
  assign buf_kill = sync_q[I_VOLT] | sync_q[I_TEMP];
  assign section  = major_q[GW-1 -: agc_pkg::SECT_W];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_switch_drive <= 1'b0;
      minor_gauge_oe      <= 1'b0;
      major_gauge_oe      <= 1'b0;
    end else begin
      supply_switch_drive <= (mode_q != agc_pkg::AGC_STANDBY) &
                             ~sync_q[I_VOLT];
      minor_gauge_oe      <= (mode_q != agc_pkg::AGC_STANDBY) &
                             ~buf_kill;
      major_gauge_oe      <= (mode_q == agc_pkg::AGC_NORMAL) &
                             ~buf_kill;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      minor_gauge_a <= '0;
      minor_gauge_b <= '0;
    end else if (mode_q == agc_pkg::AGC_NORMAL) begin
      minor_gauge_a <= minor_a_q[agc_pkg::MINOR_RES_W-1:0];
      minor_gauge_b <= minor_b_q[agc_pkg::MINOR_RES_W-1:0];
    end else begin
      // Minors held at zero until enable, so bias switch-on cannot jump
      minor_gauge_a <= '0;
      minor_gauge_b <= '0;
    end
  end

  // Two sections per quadrant: even section drives sine coil from
  // the converter, odd the cosine coil; the other coil gets bias
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      major_gauge_dac  <= '0;
      major_dac_to_cos <= 1'b0;
      major_sin_neg    <= 1'b0;
      major_cos_neg    <= 1'b0;
    end else begin
      major_gauge_dac  <= major_q[agc_pkg::DAC_W-1:0];
      major_dac_to_cos <= section[0];
      major_sin_neg    <= section[2];
      major_cos_neg    <= section[2] ^ section[1];
    end
  end

  // Run is a status bit but not a fault, so it does not pull the flag
  assign any_fault = sync_q[I_MINOC] | sync_q[I_MAJOC] | sync_q[I_TEMP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_oe_q  <= 1'b0;
      fault_drv_q <= 1'b0;
    end else begin
      fault_oe_q  <= any_fault;
      fault_drv_q <= 1'b0;
    end
  end

  // Only ever pulls low; the line's pull-up gives the high level
  assign link.fault_oe  = fault_oe_q;
  assign link.fault_drv = fault_drv_q;

endmodule

// file: hdl/agc_ctl.sv
// Controller end: AXI4-Lite registers and shift-clock frame engine
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module agc_ctl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  agc_link_if.ctl          link
);

  localparam int FW = agc_pkg::FRAME_W;
  localparam int GW = agc_pkg::GAUGE_W;
  localparam logic [agc_pkg::CNT_W-1:0] HALF =
    agc_pkg::CNT_W'(agc_pkg::SCLK_HALF_CYC - 1);

  logic [7:0]                  aw_addr_q;
  logic [31:0]                 w_data_q;
  logic [3:0]                  w_strb_q;
  logic                        do_write;
  logic                        wr_ctrl;
  logic                        goe_q;
  logic                        park_en_q;
  logic [GW-1:0]               gauge_q [3];
  logic [1:0]                  meta_q;
  logic [1:0]                  sync_q;
  agc_pkg::agc_link_st_t       st_q;
  logic [agc_pkg::CNT_W-1:0]   cnt_q;
  logic [4:0]                  bit_q;
  logic [FW-1:0]               tx_q;
  logic [FW-1:0]               rx_q;
  logic [agc_pkg::STAT_W-1:0]  ret_q;
  logic                        start_pend_q;
  logic                        park_pend_q;
  logic                        park_frame_q;
  logic                        park_done_q;
  logic                        cs_q;
  logic                        sclk_q;
  logic                        sdo_q;

  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_ctrl  = do_write & (aw_addr_q == agc_pkg::ADDR_CTRL) &
                    w_strb_q[0];

  // Address and data taken in either order; response once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= agc_pkg::RESP_OKAY;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Park completion drops the gauge enable; software write still wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      goe_q      <= 1'b0;
      park_en_q  <= 1'b0;
      gauge_q[0] <= '0;
      gauge_q[1] <= '0;
      gauge_q[2] <= '0;
    end else begin
      if (wr_ctrl) begin
        goe_q     <= w_data_q[agc_pkg::CTRL_GOE];
        park_en_q <= w_data_q[agc_pkg::CTRL_PARK];
      end else if (park_done_q) begin
        goe_q <= 1'b0;
      end
      for (int g = 0; g < 3; g++) begin
        if (do_write && aw_addr_q == agc_pkg::ADDR_MAJOR + 8'(4 * g)) begin
          if (w_strb_q[0]) gauge_q[g][7:0] <= w_data_q[7:0];
          if (w_strb_q[1]) gauge_q[g][GW-1:8] <= w_data_q[GW-1:8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= agc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      unique case (s_axi_araddr)
        agc_pkg::ADDR_CTRL:   s_axi_rdata <= {30'h0, park_en_q, goe_q};
        agc_pkg::ADDR_MAJOR:  s_axi_rdata <= {22'h0, gauge_q[0]};
        agc_pkg::ADDR_MINA:   s_axi_rdata <= {22'h0, gauge_q[1]};
        agc_pkg::ADDR_MINB:   s_axi_rdata <= {22'h0, gauge_q[2]};
        agc_pkg::ADDR_STATUS: s_axi_rdata <= {25'h0, park_pend_q, ret_q,
                                              ~sync_q[1],
                                              st_q != agc_pkg::AGC_L_IDLE};
        default:              s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Pins from the device pass two flops: [0] data out, [1] fault line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= {link.fault_flag_n, link.serial_out};
      sync_q <= meta_q;
    end
  end

  // Data changes with the clock low and is sampled just before rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= agc_pkg::AGC_L_IDLE;
      cnt_q        <= '0;
      bit_q        <= '0;
      tx_q         <= '0;
      rx_q         <= '0;
      ret_q        <= '0;
      start_pend_q <= 1'b0;
      park_pend_q  <= 1'b0;
      park_frame_q <= 1'b0;
      park_done_q  <= 1'b0;
      cs_q         <= 1'b0;
      sclk_q       <= 1'b0;
      sdo_q        <= 1'b0;
    end else begin
      park_done_q <= 1'b0;
      if (wr_ctrl && w_data_q[agc_pkg::CTRL_START]) begin
        start_pend_q <= 1'b1;
      end else if (st_q == agc_pkg::AGC_L_IDLE && !park_pend_q) begin
        start_pend_q <= 1'b0;
      end
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
      unique case (st_q)
        agc_pkg::AGC_L_IDLE: begin
          if (park_pend_q || start_pend_q) begin
            // Zero frame brings needles home before enable drops
            tx_q         <= park_pend_q ? '0 : {gauge_q[0], gauge_q[1],
                                                gauge_q[2]};
            sdo_q        <= park_pend_q ? 1'b0 : gauge_q[0][GW-1];
            park_frame_q <= park_pend_q;
            park_pend_q  <= 1'b0;
            cs_q         <= 1'b1;
            bit_q        <= '0;
            cnt_q        <= HALF;
            st_q         <= agc_pkg::AGC_L_LOW;
          end
        end
        agc_pkg::AGC_L_LOW: begin
          if (cnt_q == '0) begin
            rx_q   <= {rx_q[FW-2:0], sync_q[0]};
            sclk_q <= 1'b1;
            cnt_q  <= HALF;
            st_q   <= agc_pkg::AGC_L_HIGH;
          end
        end
        agc_pkg::AGC_L_HIGH: begin
          if (cnt_q == '0) begin
            sclk_q <= 1'b0;
            cnt_q  <= HALF;
            if (bit_q == 5'(FW - 1)) begin
              st_q <= agc_pkg::AGC_L_TAIL;
            end else begin
              tx_q  <= {tx_q[FW-2:0], 1'b0};
              sdo_q <= tx_q[FW-2];
              bit_q <= bit_q + 1'b1;
              st_q  <= agc_pkg::AGC_L_LOW;
            end
          end
        end
        agc_pkg::AGC_L_TAIL: begin
          if (cnt_q == '0) begin
            cs_q  <= 1'b0;
            cnt_q <= HALF;
            ret_q <= rx_q[agc_pkg::ST_LSB +: agc_pkg::STAT_W];
            park_done_q <= park_frame_q;
            if (park_en_q && !park_frame_q && goe_q &&
                ret_q[0] && !rx_q[agc_pkg::ST_RUN]) begin
              park_pend_q <= 1'b1;
            end
            st_q <= agc_pkg::AGC_L_GAP;
          end
        end
        agc_pkg::AGC_L_GAP: begin
          if (cnt_q == '0) begin
            st_q <= agc_pkg::AGC_L_IDLE;
          end
        end
        default: st_q <= agc_pkg::AGC_L_IDLE;
      endcase
    end
  end

  assign link.cs                  = cs_q;
  assign link.sclk                = sclk_q;
  assign link.serial_in           = sdo_q;
  assign link.gauge_output_enable = goe_q;

endmodule

// file: sim/agc_chk.sv
// Concurrent checks on the gauge link between controller and driver
`timescale 1ns/1ps
module agc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic gauge_output_enable,
  input wire logic fault_drv,
  input wire logic fault_oe,
  input wire logic fault_flag_n
);
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [7:0] stb_q;
  logic [5:0] bits_q;
  logic       sclk_q;
  logic       din_q;
  // Counters saturate so a long idle span cannot wrap into a false failure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q  <= 8'h0;
      lo_q  <= 8'h0;
      stb_q <= 8'h0;
      din_q <= 1'b0;
    end else begin
      hi_q  <= sclk ? hi_q + 8'(hi_q != 8'hFF) : 8'h0;
      lo_q  <= sclk ? 8'h0 : lo_q + 8'(lo_q != 8'hFF);
      stb_q <= (serial_in != din_q) ? 8'h0 : stb_q + 8'(stb_q != 8'hFF);
      din_q <= serial_in;
    end
  end
  always_ff @(posedge aclk) begin
    sclk_q <= aresetn ? sclk : 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !cs) begin
      bits_q <= 6'h0;
    end else if (sclk && !sclk_q) begin
      bits_q <= bits_q + 6'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_lead;
    !sclk [*8];
  endsequence
  sequence s_hold;
    $stable(serial_in) [*8];
  endsequence
  a_fault_pull_low:
    assert property (fault_oe |-> !fault_drv && !fault_flag_n)
    else $error("fault line not pulled low");
  a_fault_release:
    assert property (!fault_oe |-> fault_flag_n)
    else $error("fault line low while released");
  a_sclk_idle:
    assert property (!cs |-> !sclk)
    else $error("shift clock moves outside frame");
  a_cs_lead:
    assert property ($rose(cs) |-> s_lead)
    else $error("shift clock too soon after select");
  a_high_len:
    assert property ($fell(sclk) |-> hi_q >= 8'h2C)
    else $error("shift clock high too short");
  a_tail_len:
    assert property ($fell(cs) |-> lo_q >= 8'h13)
    else $error("select dropped too soon after clock");
  a_din_setup:
    assert property ($rose(sclk) |-> stb_q >= 8'h13)
    else $error("data setup too short");
  a_din_hold:
    assert property ($rose(sclk) |-> s_hold)
    else $error("data hold too short");
  a_frame_bits:
    assert property ($fell(cs) |-> bits_q == 6'h1E)
    else $error("frame bit count wrong");
  a_dout_still:
    assert property (!cs |-> $stable(serial_out))
    else $error("serial output moved while deselected");
endmodule

// file: sim/test_air_core_gauge_serial_ctrl.sv
// Bench joining controller and driver over the gauge link
`timescale 1ns/1ps
module test_air_core_gauge_serial_ctrl;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic        run = 0, minor_overcurrent = 0, major_overcurrent = 0;
  logic        over_temp = 0, over_volt = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        supply_switch_drive, major_gauge_oe, major_dac_to_cos;
  logic        major_sin_neg, major_cos_neg, minor_gauge_oe;
  logic [6:0]  major_gauge_dac;
  logic [8:0]  minor_gauge_a, minor_gauge_b;
  logic [29:0] sh, so, prev = 30'h0;
  logic [29:0] expq [$];
  logic        sp = 0, g = 0;
  logic [31:0] rd;
  integer      fails = 0, checks = 0, cyc = 0, seed = 32'hc5f518fb;
  integer      maj = 0, ga = 0, gb = 0, k;
  agc_link_if agc_link_if_i ();
  agc_ctl agc_ctl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .link(agc_link_if_i));
  agc_dev agc_dev_i (.aclk, .aresetn, .link(agc_link_if_i), .run,
    .minor_overcurrent, .major_overcurrent, .over_temp, .over_volt,
    .supply_switch_drive, .major_gauge_oe, .major_gauge_dac,
    .major_dac_to_cos, .major_sin_neg, .major_cos_neg, .minor_gauge_oe,
    .minor_gauge_a, .minor_gauge_b);
  agc_chk agc_chk_i (.aclk, .aresetn, .cs(agc_link_if_i.cs),
    .sclk(agc_link_if_i.sclk), .serial_in(agc_link_if_i.serial_in),
    .serial_out(agc_link_if_i.serial_out),
    .gauge_output_enable(agc_link_if_i.gauge_output_enable),
    .fault_drv(agc_link_if_i.fault_drv), .fault_oe(agc_link_if_i.fault_oe),
    .fault_flag_n(agc_link_if_i.fault_flag_n));
  always #2 aclk = ~aclk;
  task results;
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Wire monitor: rebuild the frame from what the controller shifts out
  always @(posedge aclk) begin
    sp <= agc_link_if_i.sclk;
    // Driver shifts a few clocks after the rise, so its output is still
    // the bit that goes with this rise
    if (agc_link_if_i.cs && agc_link_if_i.sclk && !sp) begin
      sh <= {sh[28:0], agc_link_if_i.serial_in};
      so <= {so[28:0], agc_link_if_i.serial_out};
    end
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails = fails + 1;
      results();
    end
  end
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Expected pins from mode, shutdown causes and the latched gauges
  task chk_pins;
    logic sb, sd;
    sb = !run && !g;
    sd = over_volt || over_temp;
    chk_val({supply_switch_drive, major_gauge_oe, minor_gauge_oe,
      major_gauge_dac, major_dac_to_cos, major_sin_neg, major_cos_neg,
      minor_gauge_a, minor_gauge_b, agc_link_if_i.fault_flag_n},
      {!sb && !over_volt, g && !sd, !sb && !sd, maj[6:0], maj[7], maj[9],
      maj[9] ^ maj[8], g ? {ga[8:0], gb[8:0]} : 18'h0,
      !(minor_overcurrent || major_overcurrent || over_temp)});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk_val({30'h0, s_axi_bresp}, {30'h0, agc_pkg::RESP_OKAY});
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task rdr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    chk_val({30'h0, s_axi_rresp}, {30'h0, agc_pkg::RESP_OKAY});
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task wait_frame;
    logic [29:0] e;
    e = expq.pop_front();
    while (agc_link_if_i.cs !== 1'b1) @(posedge aclk);
    while (agc_link_if_i.cs !== 1'b0) @(posedge aclk);
    chk_val({2'h0, sh}, {2'h0, e});
    // Returned frame: live status, then the tail of the previous frame
    chk_val({2'h0, so}, {2'h0, minor_overcurrent, major_overcurrent,
      over_temp, run, prev[25:0]});
    prev = e;
    repeat (100) @(posedge aclk);
  endtask
  task frame(input logic [31:0] c);
    expq.push_back({maj[9:0], ga[9:0], gb[9:0]});
    wr(agc_pkg::ADDR_CTRL, c);
    wait_frame();
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdr(8'h14);
    chk_val(rd, 32'h0);
    rdr(agc_pkg::ADDR_STATUS);
    chk_val(rd, 32'h0);
    // Odd passes enable outputs; even ones preload with outputs held off
    for (k = 0; k < 4; k++) begin
      maj = $random(seed) & 32'h3FF;
      ga = $random(seed) & 32'h3FF;
      gb = $random(seed) & 32'h3FF;
      g = k[0];
      {run, minor_overcurrent, major_overcurrent, over_temp, over_volt} <=
        5'($random(seed));
      wr(agc_pkg::ADDR_MAJOR, maj);
      wr(agc_pkg::ADDR_MINA, ga);
      wr(agc_pkg::ADDR_MINB, gb);
      frame({29'h0, 1'b1, 1'b0, g});
      chk_pins();
      rdr(agc_pkg::ADDR_STATUS);
      chk_val(rd, {25'h0, 1'b0, minor_overcurrent, major_overcurrent,
        over_temp, run, minor_overcurrent | major_overcurrent | over_temp,
        1'b0});
      rdr(agc_pkg::ADDR_MAJOR);
      chk_val(rd, maj);
    end
    for (k = 0; k < 16; k++) begin
      g = k[3];
      run <= k[0];
      over_volt <= k[1];
      over_temp <= k[2];
      minor_overcurrent <= 1'($random(seed));
      major_overcurrent <= 1'($random(seed));
      wr(agc_pkg::ADDR_CTRL, {31'h0, g});
      repeat (12) @(posedge aclk);
      chk_pins();
    end
    run <= 1;
    over_volt <= 0;
    over_temp <= 0;
    g = 1;
    frame(32'h7);
    run <= 0;
    frame(32'h7);
    expq.push_back(30'h0);
    wait_frame();
    maj = 0;
    ga = 0;
    gb = 0;
    g = 0;
    chk_val({31'h0, agc_link_if_i.gauge_output_enable}, 32'h0);
    chk_pins();
    results();
  end
endmodule
